// ### rtl/cpx_pkg.sv
// Overview of operation
// - reset loads reload value all ones; clocks run at oscillator over two unless the strap selects double speed.
// - reset selects main oscillator; clock output follows undivided oscillator.
// - any reload value is writable; cpu and peripheral clocks share it.
// - reload zero gives oscillator over 1020 standard, over 510 double speed.
// - reload all ones gives oscillator over two standard, undivided double speed.
// - other reloads divide by 2x(255-reload) double speed, 4x standard.
// - divide-by-two stage feeds the core; double speed mode bypasses it.
// - machine cycle is six core ticks: 12 oscillator periods standard, 6 double speed at reload all ones.
// - double speed bit takes effect only on crystal-over-two rising edge.
// - reset loads double speed bit from hardware configuration byte.
// - peripheral speed bits act only while double speed mode is on.
// - watchdog bit clear gives 6 periods per cycle, set gives 12.
// - control register at 8Fh, bit 0 mode, bits 1-6 peripherals.
// - timer, serial, counter array bits: clear 6 periods, set 12.
package cpx_pkg;

  localparam logic [7:0] CPX_ADDR_SPEED   = 8'h8f;
  localparam logic [7:0] CPX_ADDR_RELOAD  = 8'h97;
  localparam logic [6:0] CPX_SPEED_RESET  = 7'h00;
  localparam logic [7:0] CPX_RELOAD_RESET = 8'hff;
  localparam logic [7:0] CPX_RELOAD_MAX   = 8'hff;
  localparam logic [7:0] CPX_RELOAD_TERM  = 8'hfe;
  localparam logic [7:0] CPX_RDATA_IDLE   = 8'h00;
  localparam int         CPX_X2_POS       = 0;
  localparam int         CPX_PERIPH_LSB   = 1;
  localparam int         CPX_PERIPH_N     = 6;
  localparam int         CPX_WDOG_POS     = 6;
  localparam int         CPX_TIMER0_POS   = 1;
  localparam logic [2:0] CPX_MC_LAST      = 3'h5;
  localparam logic       CPX_SRC_MAIN     = 1'b0;

  typedef struct packed {
    logic       xtal_meta;
    logic       xtal_sync;
    logic       xtal_prev;
    logic       half_div;
    logic       x2_act;
    logic       pre_phase;
    logic       per_phase;
    logic       strap_done;
    logic       clk_sel;
    logic       osc_en;
    logic       cpu_en;
    logic       mc_en;
    logic [5:0] per_en;
    logic [2:0] mc_cnt;
    logic [6:0] speed;
    logic [7:0] reload;
    logic [7:0] pre_cnt;
    logic [7:0] rdata;
  } cpx_state_type;

endpackage

// ### rtl/cpx_clock_prescaler.sv
// The strobed register port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module cpx_clock_prescaler #(
  parameter int unsigned HCB_X2_BIT = 0
) (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       crystal_input_i,
  input  wire logic [7:0] hardware_config_byte_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  output logic            cpu_clk_en_o,
  output logic      [5:0] periph_clk_en_o,
  output logic            machine_cycle_en_o,
  output logic            clock_out_en_o,
  output logic            clock_source_select_o,
  output logic            double_speed_active_o
);
  import cpx_pkg::*;

  if (HCB_X2_BIT > 7) begin : g_bad_hcb
    $error("HCB_X2_BIT must address a bit of the configuration byte");
  end

  logic          rst_meta;
  logic          rst_n;
  cpx_state_type st;
  cpx_state_type nx;
  logic          osc_tick;
  logic          half_rise;
  logic          src_tick;
  logic          bypass;
  logic          cpu_tick;

  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] t);
    addr_hit = (a == t);
  endfunction

  // reset release synchroniser
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  always_comb begin
    nx           = st;
    nx.xtal_meta = crystal_input_i;
    nx.xtal_sync = st.xtal_meta;
    nx.xtal_prev = st.xtal_sync;
    osc_tick     = st.xtal_sync & ~st.xtal_prev;
    half_rise    = osc_tick & ~st.half_div;
    if (osc_tick) begin
      nx.half_div = ~st.half_div;
    end
    // mode change waits for the half-rate rising edge
    if (half_rise) begin
      nx.x2_act = st.speed[CPX_X2_POS];
    end
    // divider bypassed in double speed mode
    src_tick = st.x2_act ? osc_tick : half_rise;
    bypass   = (st.reload == CPX_RELOAD_MAX);
    cpu_tick = 1'b0;
    if (bypass) begin
      nx.pre_cnt = CPX_RDATA_IDLE;
      cpu_tick   = src_tick;
    end else if (src_tick) begin
      if (st.pre_cnt == CPX_RDATA_IDLE) begin
        // half period of 255-reload source ticks
        nx.pre_cnt   = CPX_RELOAD_TERM - st.reload;
        nx.pre_phase = ~st.pre_phase;
        cpu_tick     = st.pre_phase;
      end else begin
        nx.pre_cnt = st.pre_cnt - 8'h01;
      end
    end
    nx.cpu_en = cpu_tick;
    nx.mc_en  = cpu_tick & (st.mc_cnt == CPX_MC_LAST);
    if (cpu_tick) begin
      // six core ticks per machine cycle
      nx.mc_cnt    = nx.mc_en ? 3'h0 : st.mc_cnt + 3'h1;
      nx.per_phase = ~st.per_phase;
    end
    for (int k = 0; k < CPX_PERIPH_N; k++) begin
      // set bit halves the rate, only in double speed
      nx.per_en[k] = cpu_tick & (~st.x2_act | ~st.speed[CPX_PERIPH_LSB + k]
                     | st.per_phase);
    end
    nx.osc_en = osc_tick & (st.clk_sel == CPX_SRC_MAIN);
    // strap capture on the first cycle after release
    if (!st.strap_done) begin
      nx.strap_done         = 1'b1;
      nx.speed[CPX_X2_POS]  = hardware_config_byte_i[HCB_X2_BIT];
    end
    if (reg_wr_i) begin
      if (addr_hit(reg_addr_i, CPX_ADDR_SPEED)) begin
        nx.speed = reg_wdata_i[6:0];
      end
      if (addr_hit(reg_addr_i, CPX_ADDR_RELOAD)) begin
        nx.reload = reg_wdata_i;
      end
    end
    nx.rdata = CPX_RDATA_IDLE;
    if (reg_rd_i) begin
      if (addr_hit(reg_addr_i, CPX_ADDR_SPEED)) begin
        nx.rdata = {1'b0, st.speed};
      end else if (addr_hit(reg_addr_i, CPX_ADDR_RELOAD)) begin
        nx.rdata = st.reload;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st         <= '0;
      st.speed   <= CPX_SPEED_RESET;
      st.reload  <= CPX_RELOAD_RESET;
      st.clk_sel <= CPX_SRC_MAIN;
    end else begin
      st <= nx;
    end
  end

  assign reg_rdata_o           = st.rdata;
  assign cpu_clk_en_o          = st.cpu_en;
  assign periph_clk_en_o       = st.per_en;
  assign machine_cycle_en_o    = st.mc_en;
  assign clock_out_en_o        = st.osc_en;
  assign clock_source_select_o = st.clk_sel;
  assign double_speed_active_o = st.x2_act;

  // checking helpers
  logic [9:0] gap;
  logic       gap_ok;
  logic [2:0] mc_gap;
  logic       mc_ok;
  logic [9:0] ratio;

  assign ratio = {1'b0, CPX_RELOAD_MAX - st.reload, 1'b0};

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      gap    <= 10'h000;
      gap_ok <= 1'b0;
      mc_gap <= 3'h0;
      mc_ok  <= 1'b0;
    end else begin
      if (cpu_tick) begin
        gap    <= 10'h000;
        gap_ok <= 1'b1;
      end else if (src_tick) begin
        gap <= gap + 10'h001;
      end
      if (nx.reload != st.reload || nx.x2_act != st.x2_act) begin
        gap_ok <= 1'b0;
      end
      if (cpu_clk_en_o && machine_cycle_en_o) begin
        mc_gap <= 3'h0;
        mc_ok  <= 1'b1;
      end else if (cpu_clk_en_o) begin
        mc_gap <= mc_gap + 3'h1;
      end
    end
  end

  // oscillator ticks seen since the last source tick
  logic [1:0] osc_since;
  logic       src_seen;

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      osc_since <= 2'h0;
      src_seen  <= 1'b0;
    end else begin
      if (src_tick) begin
        osc_since <= 2'h0;
        src_seen  <= 1'b1;
      end else if (osc_tick && osc_since != 2'h3) begin
        osc_since <= osc_since + 2'h1;
      end
    end
  end

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n);

  sequence s_release;
    $rose(rst_n);
  endsequence

  sequence s_read(logic [7:0] a);
    reg_rd_i && reg_addr_i == a;
  endsequence

  sequence s_write(logic [7:0] a);
    reg_wr_i && reg_addr_i == a;
  endsequence

  chk_reset_reload: assert property (
    s_release |-> st.reload == CPX_RELOAD_RESET && !st.x2_act && !cpu_clk_en_o)
    else $error("reload not all ones after reset");

  chk_source_main: assert property (
    osc_tick |=> clock_out_en_o && clock_source_select_o == CPX_SRC_MAIN)
    else $error("clock output does not follow oscillator");

  chk_reload_write: assert property (
    s_write(CPX_ADDR_RELOAD) ##1 s_read(CPX_ADDR_RELOAD)
    |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("reload write not read back");

  chk_divide_ratio: assert property (
    cpu_tick && !bypass && gap_ok |-> gap + 10'h001 == ratio)
    else $error("prescaler ratio wrong");

  chk_bypass_rate: assert property (
    bypass && src_tick |=> cpu_clk_en_o)
    else $error("bypass does not pass source tick");

  chk_std_half: assert property (
    !st.x2_act && src_tick && src_seen |-> osc_tick && osc_since == 2'h1)
    else $error("standard mode not divided by two");

  chk_machine_cycle: assert property (
    machine_cycle_en_o && mc_ok |-> cpu_clk_en_o && mc_gap == CPX_MC_LAST)
    else $error("machine cycle not six core ticks");

  chk_mode_switch: assert property (
    $changed(st.x2_act) |-> $past(half_rise) && st.x2_act == $past(st.speed[CPX_X2_POS]))
    else $error("mode changed off the half-rate edge");

  chk_strap_load: assert property (
    s_release ##0 !reg_wr_i
    |=> st.speed[CPX_X2_POS] == $past(hardware_config_byte_i[HCB_X2_BIT]) && st.strap_done)
    else $error("double speed bit not loaded from strap");

  chk_std_periph: assert property (
    !$past(st.x2_act) |-> periph_clk_en_o == {CPX_PERIPH_N{cpu_clk_en_o}})
    else $error("peripheral tick differs in standard mode");

  chk_wdog_fast: assert property (
    $past(st.x2_act) && !$past(st.speed[CPX_WDOG_POS])
    |-> periph_clk_en_o[CPX_WDOG_POS - CPX_PERIPH_LSB] == cpu_clk_en_o)
    else $error("watchdog not fast with bit clear");

  chk_wdog_slow: assert property (
    $past(st.x2_act) && $past(st.speed[CPX_WDOG_POS]) && cpu_clk_en_o
    |-> periph_clk_en_o[CPX_WDOG_POS - CPX_PERIPH_LSB] == $past(st.per_phase))
    else $error("watchdog not halved with bit set");

  chk_timer_slow: assert property (
    $past(st.x2_act) && $past(st.speed[CPX_TIMER0_POS]) && cpu_clk_en_o
    |-> periph_clk_en_o[CPX_TIMER0_POS - CPX_PERIPH_LSB] == $past(st.per_phase))
    else $error("timer 0 not halved with bit set");

  chk_speed_read: assert property (
    s_write(CPX_ADDR_SPEED) ##1 s_read(CPX_ADDR_SPEED)
    |=> reg_rdata_o == {1'b0, $past(reg_wdata_i[6:0], 2)})
    else $error("control register read back wrong");

  // double speed bypass passes every oscillator tick
  chk_fast_bypass: assert property (
    bypass && st.x2_act && osc_tick |=> cpu_clk_en_o)
    else $error("double speed bypass not undivided");

  // core enable is a single cycle pulse
  chk_cpu_pulse: assert property (
    cpu_clk_en_o |=> !cpu_clk_en_o)
    else $error("core tick longer than one cycle");

  chk_timer_fast: assert property (
    $past(st.x2_act) && !$past(st.speed[CPX_TIMER0_POS])
    |-> periph_clk_en_o[CPX_TIMER0_POS - CPX_PERIPH_LSB] == cpu_clk_en_o)
    else $error("timer 0 not fast with bit clear");

  chk_source_fixed: assert property (
    clock_source_select_o == CPX_SRC_MAIN)
    else $error("clock source left the main oscillator");

  // register contents move only on a write or the strap
  chk_reload_hold: assert property (
    $changed(st.reload)
    |-> $past(reg_wr_i) && $past(reg_addr_i) == CPX_ADDR_RELOAD)
    else $error("reload changed without a write");

  chk_speed_hold: assert property (
    $changed(st.speed)
    |-> ($past(reg_wr_i) && $past(reg_addr_i) == CPX_ADDR_SPEED) || !$past(st.strap_done))
    else $error("control changed without a write");

  // read data idle outside the answer cycle
  chk_rdata_idle: assert property (
    !$past(reg_rd_i) |-> reg_rdata_o == CPX_RDATA_IDLE)
    else $error("read data not idle outside a read");

endmodule
`default_nettype wire

// ### testbench/cpx_crystal_osc.sv
`timescale 1ns/100ps
`default_nettype none
module cpx_crystal_osc #(
  parameter int HALF_NS = 20
) (
  output logic crystal_o
);
  // free running, even duty keeps the bypassed path legal
  initial begin
    crystal_o = 1'b0;
    // offset keeps pin edges off the sampling clock edge
    #1;
    forever #(HALF_NS) crystal_o = ~crystal_o;
  end
endmodule
`default_nettype wire

// ### testbench/cpu_clock_prescaler_x2_test.sv
`timescale 1ns/100ps
`default_nettype none
module cpu_clock_prescaler_x2_test;
  import cpx_pkg::*;
  logic       clk = 1'b0;
  logic       rst_b = 1'b1;
  logic       xtal;
  logic [7:0] hardware_config_byte = 8'h00;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] rdata;
  logic       cpu_en;
  logic [5:0] per_en;
  logic       mc_en;
  logic       osc_en;
  logic       src;
  logic       x2;
  logic [7:0] d;
  wire  [7:0] probe = {mc_en, per_en, cpu_en};
  int         bad_count = 0;
  int         comparisons = 0;
  int         r;

  always #4 clk = ~clk;

  cpx_crystal_osc i_osc (.crystal_o(xtal));

  cpx_clock_prescaler i_dut (
    .sys_clk_i(clk), .rst_b_i(rst_b), .crystal_input_i(xtal),
    .hardware_config_byte_i(hardware_config_byte), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .cpu_clk_en_o(cpu_en),
    .periph_clk_en_o(per_en), .machine_cycle_en_o(mc_en),
    .clock_out_en_o(osc_en), .clock_source_select_o(src),
    .double_speed_active_o(x2));

  task automatic stop_test;
    $display("counts: %0d compared, %0d mismatched", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask

  task automatic chk_n(input string nm, input int e, input int g);
    comparisons++;
    if (g != e) begin
      $display("ERROR %s expected %0d seen %0d", nm, e, g);
      bad_count++;
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // write then read back with no gap between the strobes
  task automatic reg_wr_rd(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // oscillator ticks between two pulses of one enable
  task automatic gap(input int sel, output int n);
    int t;
    n = 0;
    t = 0;
    do begin
      @(posedge clk);
      #1 t++;
    end while (probe[sel] !== 1'b1 && t < 20000);
    do begin
      @(posedge clk);
      #1 t++;
      n += int'(osc_en === 1'b1);
    end while (probe[sel] !== 1'b1 && t < 40000);
    if (probe[sel] !== 1'b1) begin
      $display("ERROR enable %0d expected pulse seen none", sel);
      bad_count++;
      stop_test;
    end
  endtask

  task automatic run_cfg(input logic [7:0] rel, input logic [7:0] ctl, input bit full);
    int n;
    int base;
    reg_wr(CPX_ADDR_RELOAD, rel);
    reg_wr(CPX_ADDR_SPEED, ctl);
    base = (rel == 8'hff) ? 1 : 2 * (255 - int'(rel));
    base = base * (ctl[0] ? 1 : 2);
    gap(0, n);
    gap(0, n);
    chk_n("cpu gap", base, n);
    chk8("double speed", {7'h0, ctl[0]}, {7'h0, x2});
    if (full) begin
      gap(7, n);
      chk_n("machine gap", 6 * base, n);
      for (int k = 0; k < 6; k++) begin
        gap(k + 1, n);
        chk_n("periph gap", (ctl[0] && ctl[k+1]) ? 2 * base : base, n);
      end
    end
    $display("test done: reload %h control %h", rel, ctl);
  endtask

  initial begin
    rst_b <= 1'b0;
    void'($urandom(32'haecd0e6a));
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    chk8("source", {7'h0, CPX_SRC_MAIN}, {7'h0, src});
    reg_rd(CPX_ADDR_RELOAD);
    chk8("reload reset", 8'hff, d);
    reg_rd(CPX_ADDR_SPEED);
    chk8("control reset", 8'h00, d);
    reg_wr(8'h90, 8'h55);
    reg_rd(8'h90);
    chk8("unmapped", 8'h00, d);
    r = $urandom;
    reg_wr_rd(CPX_ADDR_RELOAD, r[7:0]);
    chk8("reload rw", r[7:0], d);
    reg_wr_rd(CPX_ADDR_SPEED, {1'b0, r[14:8]});
    chk8("control rw", {1'b0, r[14:8]}, d);
    $display("test done: registers");
    run_cfg(8'hff, 8'h00, 1'b1);
    run_cfg(8'hff, 8'h01, 1'b1);
    run_cfg(8'hff, 8'h7f, 1'b1);
    run_cfg(8'hff, 8'h7e, 1'b1);
    r = 8'hf0 + $urandom_range(14, 0);
    run_cfg(r[7:0], 8'h2b, 1'b1);
    run_cfg(r[7:0], 8'h00, 1'b1);
    run_cfg(8'h00, 8'h00, 1'b0);
    run_cfg(8'h00, 8'h01, 1'b0);
    @(posedge clk);
    hardware_config_byte <= 8'h01;
    rst_b <= 1'b0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    reg_rd(CPX_ADDR_SPEED);
    chk8("strap", 8'h01, d);
    reg_rd(CPX_ADDR_RELOAD);
    chk8("reload after reset", 8'hff, d);
    $display("test done: strap");
    stop_test;
  end
endmodule
`default_nettype wire
